// file: hw/dmia_core.sv
`timescale 1ns/1ps
`default_nettype none
module dmia_core #(
  parameter int NUM_SECT = dmia_pkg::NUM_SECT
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_acc_valid,    // data memory access this cycle
  input  wire logic        i_acc_write,    // write when high, read when low
  input  wire logic [11:0] i_acc_addr,     // extended address, sector:location
  input  wire logic [1:0]  i_wsrc,         // write data source
  input  wire logic [7:0]  i_alu_result,   // alu result
  input  wire logic        i_acc_load_alu, // store alu result in accumulator
  input  wire logic        i_acc_load_mem, // load read data into accumulator
  input  wire logic        i_branch,       // jump or call this cycle
  input  wire logic [12:0] i_branch_target,// target within a bank
  output var  logic [7:0]  o_rdata,        // read data, one cycle after request
  output var  logic        o_rvalid,       // read data valid strobe
  output var  logic [7:0]  o_acc,          // accumulator contents
  output var  logic        o_bank,         // selected program bank
  output var  logic [13:0] o_branch_pc,    // full branch address
  output var  logic        o_branch_valid  // branch address valid
);
  // decode: location lies in the general purpose half of a sector
  function automatic logic is_gpr(input logic [7:0] loc);
    return loc >= dmia_pkg::GPR_BASE;
  endfunction : is_gpr

  // pointer and control state
  logic [7:0]  ptr0_q, ptr0_d;
  logic [7:0]  ptr1l_q, ptr1l_d;
  logic [7:0]  ptr1s_q, ptr1s_d;
  logic [7:0]  ptr2l_q, ptr2l_d;
  logic [7:0]  ptr2s_q, ptr2s_d;
  logic        bank_q, bank_d;
  logic [7:0]  acc_q, acc_d;
  logic [7:0]  rsvd_q;                     // reserved location, never written
  // resolved address and read path
  logic [11:0] eff_addr;                   // address after redirection
  logic        eff_port;                   // access hit a port location itself
  logic [7:0]  wdata;                      // selected write data
  logic        ram_we;
  logic [10:0] ram_addr;
  logic [7:0]  ram_rdata;
  logic [7:0]  sfr_rd_d, sfr_rd_q;         // special register read value
  logic        rd_gpr_d, rd_gpr_q;         // read came from ram
  logic        rvalid_q;
  logic [7:0]  brd_loc;                    // location part of resolved address
  logic [3:0]  brd_sect;                   // sector part of resolved address

  // redirect through the pointers
  always_comb begin
    eff_addr = i_acc_addr;
    eff_port = 1'b0;
    if (i_acc_addr[11:8] == 4'h0) begin
      unique case (i_acc_addr[7:0])
        dmia_pkg::LOC_PORT0: begin
          eff_addr = {4'h0, ptr0_q};
        end
        dmia_pkg::LOC_PORT1: begin
          eff_addr = {ptr1s_q[3:0], ptr1l_q};
        end
        dmia_pkg::LOC_PORT2: begin
          eff_addr = {ptr2s_q[3:0], ptr2l_q};
        end
        default: begin
          eff_addr = i_acc_addr;
        end
      endcase
    end
    // a pointer aimed at a port location itself finds no storage
    if (eff_addr[11:8] == 4'h0 && (eff_addr[7:0] == dmia_pkg::LOC_PORT0 ||
        eff_addr[7:0] == dmia_pkg::LOC_PORT1 || eff_addr[7:0] == dmia_pkg::LOC_PORT2)) begin
      eff_port = 1'b1;
    end
  end

  assign brd_loc  = eff_addr[7:0];
  assign brd_sect = eff_addr[11:8];

  // write data: memory writes only come from the accumulator or alu
  always_comb begin
    unique case (i_wsrc)
      2'd1:    wdata = acc_q;
      2'd2:    wdata = i_alu_result;
      default: wdata = acc_q;
    endcase
  end

  // ram control, general purpose half of each sector
  assign ram_we   = i_acc_valid && i_acc_write && is_gpr(brd_loc);
  assign ram_addr = {brd_sect, brd_loc[6:0]};

  dmia_ram #(
    .DEPTH (dmia_pkg::RAM_DEPTH),
    .AW    (11)
  ) u_ram (
    .i_ref_clk (i_ref_clk),
    .i_we      (ram_we),
    .i_addr    (ram_addr),
    .i_wdata   (wdata),
    .o_rdata   (ram_rdata)
  );

  // next state of pointers, bank and accumulator
  always_comb begin
    ptr0_d   = ptr0_q;
    ptr1l_d  = ptr1l_q;
    ptr1s_d  = ptr1s_q;
    ptr2l_d  = ptr2l_q;
    ptr2s_d  = ptr2s_q;
    bank_d   = bank_q;
    acc_d    = acc_q;
    sfr_rd_d = dmia_pkg::UNUSED_READ;
    rd_gpr_d = 1'b0;
    if (i_acc_valid && !eff_port && brd_sect == 4'h0 && !is_gpr(brd_loc)) begin
      unique case (brd_loc)
        dmia_pkg::LOC_PTR0: begin
          sfr_rd_d = ptr0_q;
          if (i_acc_write) ptr0_d = wdata;
        end
        dmia_pkg::LOC_PTR1_LOW: begin
          sfr_rd_d = ptr1l_q;
          if (i_acc_write) ptr1l_d = wdata;
        end
        dmia_pkg::LOC_PTR1_SECT: begin
          sfr_rd_d = ptr1s_q;
          if (i_acc_write) ptr1s_d = wdata;
        end
        dmia_pkg::LOC_PTR2_LOW: begin
          sfr_rd_d = ptr2l_q;
          if (i_acc_write) ptr2l_d = wdata;
        end
        dmia_pkg::LOC_PTR2_SECT: begin
          sfr_rd_d = ptr2s_q;
          if (i_acc_write) ptr2s_d = wdata;
        end
        dmia_pkg::LOC_ACC: begin
          sfr_rd_d = acc_q;
          if (i_acc_write) acc_d = wdata;
        end
        dmia_pkg::LOC_BANK: begin
          sfr_rd_d = {7'h00, bank_q};
          if (i_acc_write) bank_d = wdata[dmia_pkg::BANK_BIT];
        end
        dmia_pkg::LOC_RSVD_A: begin
          sfr_rd_d = rsvd_q;
        end
        default: begin
          sfr_rd_d = dmia_pkg::UNUSED_READ;
        end
      endcase
    end
    if (i_acc_valid && !eff_port && is_gpr(brd_loc)) begin
      rd_gpr_d = 1'b1;
    end
    // accumulator loads win over a memory write to its own location
    if (i_acc_load_alu) begin
      acc_d = i_alu_result;
    end
    // returning read data overrides the alu load
    if (i_acc_load_mem && rvalid_q) begin
      acc_d = o_rdata;
    end
  end

  // register the state
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      ptr0_q   <= dmia_pkg::PTR_RST;
      ptr1l_q  <= dmia_pkg::PTR_RST;
      ptr1s_q  <= dmia_pkg::PTR_RST;
      ptr2l_q  <= dmia_pkg::PTR_RST;
      ptr2s_q  <= dmia_pkg::PTR_RST;
      bank_q   <= 1'b0;
      acc_q    <= dmia_pkg::ACC_RST;
      rsvd_q   <= dmia_pkg::UNUSED_READ;
      sfr_rd_q <= dmia_pkg::UNUSED_READ;
      rd_gpr_q <= 1'b0;
      rvalid_q <= 1'b0;
    end else begin
      ptr0_q   <= ptr0_d;
      ptr1l_q  <= ptr1l_d;
      ptr1s_q  <= ptr1s_d;
      ptr2l_q  <= ptr2l_d;
      ptr2s_q  <= ptr2s_d;
      bank_q   <= bank_d;
      acc_q    <= acc_d;
      sfr_rd_q <= sfr_rd_d;
      rd_gpr_q <= rd_gpr_d;
      rvalid_q <= i_acc_valid && !i_acc_write;
    end
  end

  // read data and branch outputs
  assign o_rdata        = rd_gpr_q ? ram_rdata : sfr_rd_q;
  assign o_rvalid       = rvalid_q;
  assign o_acc          = acc_q;
  assign o_bank         = bank_q;
  assign o_branch_pc    = {bank_q, i_branch_target};
  assign o_branch_valid = i_branch;

  a_bank_reads_zero: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_acc_valid && !i_acc_write && i_acc_addr == {4'h0, dmia_pkg::LOC_BANK})
      |=> o_rdata[7:1] == 7'h00)
    else $error("bank register upper bits not zero");
  a_port_reads_zero: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_acc_valid && !i_acc_write && eff_port) |=> o_rdata == 8'h00)
    else $error("port location read not zero");
  a_bank_write_takes: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_acc_valid && i_acc_write && i_acc_addr == {4'h0, dmia_pkg::LOC_BANK} && !eff_port)
      |=> o_bank == $past(wdata[0]))
    else $error("bank bit did not follow write");
  a_branch_bank: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    i_branch |-> o_branch_pc[13] == o_bank)
    else $error("branch bank wrong");
  a_acc_alu_load: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_acc_load_alu && !(i_acc_load_mem && rvalid_q)) |=> o_acc == $past(i_alu_result))
    else $error("accumulator missed alu result");
  a_port0_sector0: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_acc_addr == {4'h0, dmia_pkg::LOC_PORT0}) |-> eff_addr[11:8] == 4'h0)
    else $error("first port left sector zero");
  a_port1_redirect: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_acc_addr == {4'h0, dmia_pkg::LOC_PORT1}) |-> eff_addr == {ptr1s_q[3:0], ptr1l_q})
    else $error("second port redirect wrong");
  a_ptr_write_read: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_acc_valid && i_acc_write && i_acc_addr == {4'h0, dmia_pkg::LOC_PTR0})
      |=> ptr0_q == $past(wdata))
    else $error("pointer did not hold written value");
  a_rsvd_hold: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_acc_valid && !i_acc_write && i_acc_addr == {4'h0, dmia_pkg::LOC_RSVD_A})
      |=> o_rdata == dmia_pkg::UNUSED_READ)
    else $error("reserved location changed");
endmodule : dmia_core
`default_nettype wire

// file: hw/dmia_pkg.sv
package dmia_pkg;
  // address layout
  localparam int ADDR_W      = 12;          // extended address width
  localparam int SECT_W      = 4;           // sector field width
  localparam int NUM_SECT    = 16;          // sectors in data memory
  localparam int RAM_DEPTH   = 2048;        // general purpose bytes
  // sector 0 special register locations
  localparam logic [7:0] LOC_PORT0     = 8'h00;  // indirect_port_zero
  localparam logic [7:0] LOC_PTR0      = 8'h01;  // sector0_pointer
  localparam logic [7:0] LOC_PORT1     = 8'h02;  // indirect_port_one
  localparam logic [7:0] LOC_PTR1_LOW  = 8'h03;  // pointer_one_low
  localparam logic [7:0] LOC_PTR1_SECT = 8'h04;  // pointer_one_sector
  localparam logic [7:0] LOC_ACC       = 8'h05;  // accumulator
  localparam logic [7:0] LOC_BANK      = 8'h0a;  // program_bank_select
  localparam logic [7:0] LOC_PORT2     = 8'h0b;  // indirect_port_two
  localparam logic [7:0] LOC_PTR2_LOW  = 8'h0c;  // pointer_two_low
  localparam logic [7:0] LOC_PTR2_SECT = 8'h0d;  // pointer_two_sector
  localparam logic [7:0] LOC_RSVD_A    = 8'h7e;  // reserved, value held
  localparam logic [7:0] GPR_BASE      = 8'h80;  // first general purpose location
  // reset values
  localparam logic [7:0] BANK_RST      = 8'h00;
  localparam logic [7:0] PTR_RST       = 8'h00;
  localparam logic [7:0] ACC_RST       = 8'h00;
  localparam logic [7:0] UNUSED_READ   = 8'h00;
  localparam int         BANK_BIT      = 0;      // bank_select_bit position
  // access sources
  typedef enum logic [1:0] {DMIA_SRC_MEM, DMIA_SRC_ACC, DMIA_SRC_ALU} dmia_src_t;
endpackage : dmia_pkg

// file: hw/dmia_ram.sv
`timescale 1ns/1ps
`default_nettype none
// general purpose byte store, registered read data
module dmia_ram #(
  parameter int DEPTH = 2048,
  parameter int AW    = 11
) (
  input  wire logic          i_ref_clk,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [7:0]    i_wdata,
  output var  logic [7:0]    o_rdata
);
  logic [7:0] mem [DEPTH];  // storage array
  // write and registered read
  always_ff @(posedge i_ref_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end
endmodule : dmia_ram
`default_nettype wire

// file: testbench/dmia_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the address resolution core
module dmia_core_tb_top;
  logic        i_ref_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        valid, write, ld_alu, ld_mem, branch, rvalid, bank, bvalid;
  logic [11:0] addr;
  logic [1:0]  wsrc;
  logic [7:0]  alu, rdata, acc;
  logic [12:0] target;
  logic [13:0] bpc;
  logic [8:0]  r;
  logic [14:0] b;
  int          num_errors = 0;
  int          checks = 0;
  localparam logic [1:0] ALU = dmia_pkg::DMIA_SRC_ALU;
  always #5 i_ref_clk = ~i_ref_clk;
  dmia_core DUT (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_acc_valid(valid),
    .i_acc_write(write), .i_acc_addr(addr), .i_wsrc(wsrc), .i_alu_result(alu),
    .i_acc_load_alu(ld_alu), .i_acc_load_mem(ld_mem), .i_branch(branch),
    .i_branch_target(target), .o_rdata(rdata), .o_rvalid(rvalid), .o_acc(acc),
    .o_bank(bank), .o_branch_pc(bpc), .o_branch_valid(bvalid));
  dmia_cpu_model cpu (.i_ref_clk(i_ref_clk), .i_rvalid(rvalid), .i_rdata(rdata),
    .i_branch_pc(bpc), .i_branch_valid(bvalid), .o_valid(valid), .o_write(write),
    .o_addr(addr), .o_wsrc(wsrc), .o_alu(alu), .o_ld_alu(ld_alu), .o_ld_mem(ld_mem),
    .o_branch(branch), .o_target(target));
  // compare and count
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  // store an alu value
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    cpu.access(1'b1, a, ALU, v, 1'b0, r);
  endtask : wr
  // read with strobe expected high
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    cpu.access(1'b0, a, ALU, 8'h00, 1'b0, r);
    chk($sformatf("read %h", a), {7'h00, r}, {8'h01, e});
  endtask : rd
  // verdict
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  // cleared state after reset
  task automatic t_reset();
    chk("acc", {8'h00, acc}, 16'h0000);
    chk("bank", {15'h0000, bank}, 16'h0000);
    rd(12'h00a, 8'h00);
  endtask : t_reset
  // pointer bytes and direct locations in several sectors
  task automatic t_store();
    logic [11:0] loc [9] = '{12'h001, 12'h003, 12'h004, 12'h00c, 12'h00d,
                             12'h185, 12'h085, 12'h3a7, 12'hff0};
    for (int i = 0; i < 9; i++) begin
      wr(loc[i], 8'h11 * 8'(i + 1));
    end
    for (int i = 0; i < 9; i++) begin
      rd(loc[i], 8'h11 * 8'(i + 1));
    end
  endtask : t_store
  // redirection through the three ports
  task automatic t_indirect();
    wr(12'h001, 8'h85);
    rd(12'h000, 8'h77);
    wr(12'h000, 8'h6a);
    rd(12'h085, 8'h6a);
    rd(12'h185, 8'h66);
    wr(12'h004, 8'h03);
    wr(12'h003, 8'ha7);
    rd(12'h002, 8'h88);
    wr(12'h00d, 8'h0f);
    wr(12'h00c, 8'hf0);
    wr(12'h00b, 8'h5c);
    rd(12'hff0, 8'h5c);
  endtask : t_indirect
  // port 0 aimed at port locations, reserved and unused places
  task automatic t_empty();
    wr(12'h001, 8'h00);
    rd(12'h000, 8'h00);
    wr(12'h000, 8'h55);
    rd(12'h001, 8'h00);
    wr(12'h001, 8'h02);
    rd(12'h000, 8'h00);
    wr(12'h07e, 8'hff);
    rd(12'h07e, 8'h00);
    wr(12'h040, 8'hab);
    rd(12'h040, 8'h00);
  endtask : t_empty
  // bank bit, unused bits and branch targets
  task automatic t_bank();
    wr(12'h00a, 8'hff);
    rd(12'h00a, 8'h01);
    chk("bank", {15'h0000, bank}, 16'h0001);
    cpu.jump(13'h1abc, b);
    chk("branch", {1'b0, b}, {2'b01, 1'b1, 13'h1abc});
    wr(12'h00a, 8'hfe);
    rd(12'h00a, 8'h00);
    cpu.jump(13'h0123, b);
    chk("branch", {1'b0, b}, {2'b01, 1'b0, 13'h0123});
  endtask : t_bank
  // alu into accumulator, memory to memory through it
  task automatic t_acc();
    cpu.alu_load(8'h3c);
    chk("acc", {8'h00, acc}, 16'h003c);
    rd(12'h005, 8'h3c);
    cpu.access(1'b0, 12'h3a7, ALU, 8'h00, 1'b1, r);
    chk("acc", {8'h00, acc}, 16'h0088);
    cpu.access(1'b1, 12'h2b0, dmia_pkg::DMIA_SRC_ACC, 8'h00, 1'b0, r);
    rd(12'h2b0, 8'h88);
  endtask : t_acc
  // main sequence
  initial begin
    repeat (16) @(negedge i_ref_clk);
    i_reset_n = 1'b1;
    t_reset();
    t_store();
    t_indirect();
    t_empty();
    t_bank();
    t_acc();
    end_sim();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    num_errors++;
    end_sim();
  end
endmodule : dmia_core_tb_top
`default_nettype wire

// file: testbench/dmia_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// cpu side: issues accesses, alu loads and branches on the falling edge
module dmia_cpu_model (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rvalid,
  input  wire logic [7:0]  i_rdata,
  input  wire logic [13:0] i_branch_pc,
  input  wire logic        i_branch_valid,
  output var  logic        o_valid,
  output var  logic        o_write,
  output var  logic [11:0] o_addr,
  output var  logic [1:0]  o_wsrc,
  output var  logic [7:0]  o_alu,
  output var  logic        o_ld_alu,
  output var  logic        o_ld_mem,
  output var  logic        o_branch,
  output var  logic [12:0] o_target
);
  // idle from time zero
  initial begin
    {o_valid, o_write, o_addr, o_wsrc, o_alu} = '0;
    {o_ld_alu, o_ld_mem, o_branch, o_target} = '0;
  end
  // one access; load strobe held over the read data cycle
  task automatic access(input logic w, input logic [11:0] a, input logic [1:0] s,
                        input logic [7:0] v, input logic ld, output logic [8:0] r);
    @(negedge i_ref_clk);
    {o_valid, o_write, o_addr, o_wsrc, o_alu, o_ld_mem} = {1'b1, w, a, s, v, ld};
    @(negedge i_ref_clk);
    r = {i_rvalid, i_rdata};
    o_valid = 1'b0;
    o_addr = ~a;  // scrambled so a stale address cannot pass
    @(negedge i_ref_clk);
    o_ld_mem = 1'b0;
  endtask : access
  // alu result into accumulator
  task automatic alu_load(input logic [7:0] v);
    @(negedge i_ref_clk);
    {o_ld_alu, o_alu} = {1'b1, v};
    @(negedge i_ref_clk);
    o_ld_alu = 1'b0;
  endtask : alu_load
  // branch held for one cycle, address sampled 1 ns after the target is driven
  task automatic jump(input logic [12:0] t, output logic [14:0] r);
    @(negedge i_ref_clk);
    {o_branch, o_target} = {1'b1, t};
    #1;
    r = {i_branch_valid, i_branch_pc};
    @(negedge i_ref_clk);
    o_branch = 1'b0;
  endtask : jump
endmodule : dmia_cpu_model
`default_nettype wire
